// file: verif/cix_core_props.sv
// cix_core_props: port-level checks of cix_core
// assumes one clock domain and the active-low async reset
module cix_core_props import cix_pkg::*; (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic valid_i,
  input cix_pkg::cix_instr_t instr_i,
  input wire logic ready_o,
  input wire logic done_o,
  input wire logic [10:0] pc_o,
  input wire logic [7:0] wreg_o,
  input cix_pkg::cix_flags_t flags_o,
  input wire logic [7:0] interrupt_control_reg_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  cix_op_t op;
  logic tk;
  logic ret;
  assign op = instr_i.op;
  assign tk = valid_i && ready_o;
  assign ret = tk && op inside {[CIX_OP_SUB_EXIT:CIX_OP_INT_EXIT]};
  a_idle_step: assert property (tk && op == CIX_OP_IDLE_STEP |=> done_o
    && pc_o == $past(pc_o) + 11'h001 && $stable(wreg_o) && $stable(flags_o))
    else $error("idle step changed state");
  a_ret_two: assert property (ret |=> !ready_o ##1 ready_o && done_o)
    else $error("return not two cycles");
  a_jump_pc: assert property (tk && op == CIX_OP_DIRECT_JUMP |=>
    pc_o == $past(instr_i.target) && $stable(flags_o))
    else $error("jump target wrong");
  a_imm_load: assert property (tk && op == CIX_OP_COPY_IMM_TO_WREG |=>
    wreg_o == $past(instr_i.imm) && $stable(flags_o))
    else $error("immediate load wrong");
  a_or_imm: assert property (tk && op == CIX_OP_OR_IMM |=>
    wreg_o == ($past(wreg_o) | $past(instr_i.imm)))
    else $error("or immediate wrong");
  a_zero_flag: assert property (tk && op == CIX_OP_OR_IMM |=>
    flags_o.z == (wreg_o == 8'h00))
    else $error("zero flag wrong");
  a_ret_value: assert property (tk && op == CIX_OP_SUB_EXIT_VALUE |=>
    ##1 wreg_o == $past(instr_i.imm, 2))
    else $error("return value wrong");
  a_irq_enable: assert property (tk && op == CIX_OP_INT_EXIT |=> ##1 interrupt_control_reg_o[0])
    else $error("global enable not set");
  a_ovac_fixed: assert property (!flags_o.ov && !flags_o.ac)
    else $error("ov or ac changed");
  c_ret: cover property (ret);
  c_call: cover property (tk && op == CIX_OP_CALL);
  c_rrc: cover property (tk && op == CIX_OP_ROT_RC_WREG);
endmodule // cix_core_props

// file: verif/tb_cix_core.sv
// tb_cix_core: directed and random run of cix_core against a model
// assumes ram is seen only through copies into the working register
module tb_cix_core;
  timeunit 1ns;
  timeprecision 1ps;
  import cix_pkg::*;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic valid_i = 1'b0;
  cix_instr_t instr_i = '0;
  logic ready_o;
  logic done_o;
  logic [10:0] pc_o;
  logic [7:0] wreg_o;
  logic [7:0] interrupt_control_reg_o;
  cix_flags_t flags_o;
  int n_fail = 0;
  int num_checks = 0;
  int mem[128];
  int w = 0;
  int c = 0;
  int z = 0;
  int pc = 0;
  int ie = 0;
  int stk[$];
  always #4 clk_i = ~clk_i;
  cix_core uut (.clk_i(clk_i), .nrst_i(nrst_i), .valid_i(valid_i),
    .instr_i(instr_i), .ready_o(ready_o), .done_o(done_o), .pc_o(pc_o),
    .wreg_o(wreg_o), .flags_o(flags_o), .interrupt_control_reg_o(interrupt_control_reg_o));
  task automatic check(logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks=%0d fails=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // op masks by enum position: zero updaters, memory writers, wreg writers
  task automatic ex(int o, int a, int i, int t);
    int m, r, ret;
    // stack kept within four levels, model cannot track a wrap
    if (o == 4 && stk.size() == 4 || o inside {[11:13]} && stk.size() == 0)
      o = 0;
    ret = o inside {[11:13]};
    m = mem[a];
    @(posedge clk_i);
    valid_i <= 1'b1;
    instr_i <= '{op: cix_op_t'(o), addr: a[6:0], imm: i[7:0], target: t[10:0]};
    // done is a one-cycle pulse: it must have dropped before the next offer
    #1 check(done_o, 0);
    @(negedge clk_i);
    while (!ready_o) @(negedge clk_i);
    @(posedge clk_i);
    valid_i <= 1'b0;
    if (ret) begin
      #1 check(ready_o, 0);
      @(posedge clk_i);
    end
    #1 check(done_o, 1);
    r = o inside {6, 9, 12} ? i : o == 7 ? w : m;
    case (cix_op_t'(o))
      CIX_OP_INC_MEM, CIX_OP_INC_WREG: r = (m + 1) % 256;
      CIX_OP_ROT_L, CIX_OP_ROT_L_WREG: r = (m * 2 + m / 128) % 256;
      CIX_OP_ROT_R, CIX_OP_ROT_R_WREG: r = m / 2 + m % 2 * 128;
      CIX_OP_ROT_LC, CIX_OP_ROT_LC_WREG: r = (m * 2 + c) % 256;
      CIX_OP_ROT_RC, CIX_OP_ROT_RC_WREG: r = m / 2 + c * 128;
      default: ;
    endcase
    if (o inside {[8:10]}) r = r | w;
    if (o inside {16, 17}) c = m / 128;
    if (o inside {20, 21}) c = m % 2;
    if (32'h0000_0706 >> o & 1) z = r == 0;
    if (32'h0015_4482 >> o & 1) mem[a] = r;
    if (32'h002a_9364 >> o & 1) w = r;
    if (o == 13) ie = 1;
    if (o == 4) stk.push_back((pc + 1) % 2048);
    pc = ret ? stk.pop_back() : o inside {3, 4} ? t : (pc + 1) % 2048;
    check(pc_o, pc);
    check(wreg_o, w);
    check(flags_o, z * 4 + c);
    check(interrupt_control_reg_o, ie);
  endtask
  initial begin
    void'($urandom(14));
    repeat (20) @(posedge clk_i);
    nrst_i <= 1'b1;
    for (int k = 0; k < 10; k++) begin
      ex(6, 0, $urandom % 256, 0);
      ex(7, k, 0, 0);
    end
    // increment wrapping to zero, then zero result of an or
    ex(6, 0, 255, 0);
    ex(7, 9, 0, 0);
    ex(1, 9, 0, 0);
    ex(2, 9, 0, 0);
    ex(6, 0, 0, 0);
    ex(9, 0, 0, 0);
    ex(4, 0, 0, 2047);
    ex(4, 0, 0, 5);
    ex(12, 0, 90, 0);
    ex(13, 0, 0, 0);
    repeat (400) ex($urandom % 22, $urandom % 8, $urandom % 256, $urandom % 2048);
    for (int k = 0; k < 10; k++) ex(5, k, 0, 0);
    summarize();
  end
  initial begin
    #100us;
    n_fail++;
    summarize();
  end
endmodule // tb_cix_core
bind cix_core cix_core_props chk (.clk_i(clk_i), .nrst_i(nrst_i),
  .valid_i(valid_i), .instr_i(instr_i), .ready_o(ready_o), .done_o(done_o),
  .pc_o(pc_o), .wreg_o(wreg_o), .flags_o(flags_o), .interrupt_control_reg_o(interrupt_control_reg_o));

// file: verilog/cix_alu.sv
// cix_alu: combinational result, carry and destination select
// assumes operand byte and working register are stable for the cycle
module cix_alu (
  input cix_pkg::cix_op_t op_i,
  input wire logic [7:0] mem_i,
  input wire logic [7:0] wreg_i,
  input wire logic [7:0] imm_i,
  input wire logic carry_i,
  output cix_pkg::cix_alu_t res_o
);
  import cix_pkg::*;

  wire logic [DATA_W-1:0] inc_val = mem_i + BYTE_ONE;
  wire logic [DATA_W-1:0] or_mem = wreg_i | mem_i;
  wire logic [DATA_W-1:0] or_imm = wreg_i | imm_i;
  wire logic [DATA_W-1:0] rot_l = {mem_i[MSB-1:0], mem_i[MSB]};
  wire logic [DATA_W-1:0] rot_lc = {mem_i[MSB-1:0], carry_i};
  wire logic [DATA_W-1:0] rot_r = {mem_i[0], mem_i[MSB:1]};
  wire logic [DATA_W-1:0] rot_rc = {carry_i, mem_i[MSB:1]};

  always_comb begin
    res_o = '{result: wreg_i, wr_wreg: 1'b0, wr_mem: 1'b0,
              upd_z: 1'b0, upd_c: 1'b0, carry: carry_i};
    unique case (op_i)
      CIX_OP_INC_MEM: res_o = '{inc_val, 1'b0, 1'b1, 1'b1, 1'b0, carry_i};
      CIX_OP_INC_WREG: res_o = '{inc_val, 1'b1, 1'b0, 1'b1, 1'b0, carry_i};
      CIX_OP_COPY_MEM_TO_WREG: res_o = '{mem_i, 1'b1, 1'b0, 1'b0, 1'b0, carry_i};
      CIX_OP_COPY_IMM_TO_WREG, CIX_OP_SUB_EXIT_VALUE:
        res_o = '{imm_i, 1'b1, 1'b0, 1'b0, 1'b0, carry_i};
      CIX_OP_COPY_WREG_TO_MEM: res_o = '{wreg_i, 1'b0, 1'b1, 1'b0, 1'b0, carry_i};
      CIX_OP_OR_MEM: res_o = '{or_mem, 1'b1, 1'b0, 1'b1, 1'b0, carry_i};
      CIX_OP_OR_IMM: res_o = '{or_imm, 1'b1, 1'b0, 1'b1, 1'b0, carry_i};
      CIX_OP_OR_TO_MEM: res_o = '{or_mem, 1'b0, 1'b1, 1'b1, 1'b0, carry_i};
      CIX_OP_ROT_L: res_o = '{rot_l, 1'b0, 1'b1, 1'b0, 1'b0, carry_i};
      CIX_OP_ROT_L_WREG: res_o = '{rot_l, 1'b1, 1'b0, 1'b0, 1'b0, carry_i};
      CIX_OP_ROT_LC: res_o = '{rot_lc, 1'b0, 1'b1, 1'b0, 1'b1, mem_i[MSB]};
      CIX_OP_ROT_LC_WREG: res_o = '{rot_lc, 1'b1, 1'b0, 1'b0, 1'b1, mem_i[MSB]};
      CIX_OP_ROT_R: res_o = '{rot_r, 1'b0, 1'b1, 1'b0, 1'b0, carry_i};
      CIX_OP_ROT_R_WREG: res_o = '{rot_r, 1'b1, 1'b0, 1'b0, 1'b0, carry_i};
      CIX_OP_ROT_RC: res_o = '{rot_rc, 1'b0, 1'b1, 1'b0, 1'b1, mem_i[0]};
      CIX_OP_ROT_RC_WREG: res_o = '{rot_rc, 1'b1, 1'b0, 1'b0, 1'b1, mem_i[0]};
      default: ; // control-flow ops touch no data path
    endcase
  end
endmodule // cix_alu

// file: verilog/cix_core.sv
// cix_core: executes one decoded instruction of the subset per request
// assumes decode outside; data memory held here as a local array
// Functional notes
// - increment memory byte in place, update zero flag
// - memory byte plus one into working register, memory kept, zero updated
// - direct jump replaces program counter bits 0..10, no flags
// - copy memory byte unchanged into working register
// - immediate byte loaded into working register, flags untouched
// - working register stored to memory byte, no flag touched
// - idle step only advances program counter by one
// - working register OR memory byte into working register, zero updated
// - working register OR immediate into working register, zero updated
// - working register OR memory byte back to memory, zero updated
// - subroutine exit pops program counter, two cycles, no flags
// - exit with value pops program counter and loads immediate
// - interrupt exit pops program counter and sets global enable bit 0
// - rotate memory left, bit 7 into bit 0, written back
// - left rotation of memory byte into working register, memory kept
// - rotate memory left through carry, written back
// - left rotation through carry into working register, carry updated
// - rotate memory right, bit 0 into bit 7, written back
// - right rotation of memory byte into working register, memory kept
// - rotate memory right through carry, written back
// - right rotation through carry into working register, carry updated
// - call pushes address of next instruction before jumping
module cix_core (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic valid_i,
  input cix_pkg::cix_instr_t instr_i,
  output logic ready_o,
  output logic done_o,
  output logic [10:0] pc_o,
  output logic [7:0] wreg_o,
  output cix_pkg::cix_flags_t flags_o,
  output logic [7:0] interrupt_control_reg_o
);
  import cix_pkg::*;

  typedef enum {
    CIX_ST_EXEC,
    CIX_ST_POP
  } cix_state_t;

  cix_state_t state;
  cix_state_t next_state;
  logic [DATA_W-1:0] ram [RAM_DEPTH];
  logic [PC_W-1:0] pc;
  logic [DATA_W-1:0] wreg;
  cix_flags_t flags;
  logic [DATA_W-1:0] interrupt_control_reg;
  cix_op_t pend_op;
  logic [DATA_W-1:0] pend_imm;
  logic done;
  logic ready;
  cix_alu_t alu;
  logic [PC_W-1:0] stack_top;

  wire logic take = valid_i && ready;
  wire logic [DATA_W-1:0] mem_rd = ram[instr_i.addr];
  wire logic is_ret = instr_i.op == CIX_OP_SUB_EXIT ||
                      instr_i.op == CIX_OP_SUB_EXIT_VALUE ||
                      instr_i.op == CIX_OP_INT_EXIT;
  wire logic is_call = take && instr_i.op == CIX_OP_CALL;
  wire logic pop = state == CIX_ST_POP;
  wire logic [PC_W-1:0] pc_inc = pc + PC_ONE;
  wire logic zero_res = alu.result == BYTE_ZERO;
  wire logic jump = instr_i.op == CIX_OP_DIRECT_JUMP ||
                    instr_i.op == CIX_OP_CALL;

  cix_alu u_alu (
    .op_i(take ? instr_i.op : CIX_OP_IDLE_STEP),
    .mem_i(mem_rd),
    .wreg_i(wreg),
    .imm_i(instr_i.imm),
    .carry_i(flags.c),
    .res_o(alu)
  );

  cix_stack u_stack (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .push_i(is_call),
    .pop_i(pop),
    .push_addr_i(pc_inc),
    .top_o(stack_top)
  );

  // returns hold the bus one extra cycle, giving the two-cycle timing
  assign next_state = (take && is_ret) ? CIX_ST_POP : CIX_ST_EXEC;
  assign ready_o = ready;
  assign done_o = done;
  assign pc_o = pc;
  assign wreg_o = wreg;
  assign flags_o = flags;
  assign interrupt_control_reg_o = interrupt_control_reg;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= CIX_ST_EXEC;
      ready <= 1'b1;
      done <= 1'b0;
      pend_op <= CIX_OP_IDLE_STEP;
      pend_imm <= BYTE_ZERO;
    end else begin
      state <= next_state;
      // ready kept as its own flop so the port carries no decode glitches
      ready <= next_state == CIX_ST_EXEC;
      done <= (take && !is_ret) || pop;
      if (take) begin
        pend_op <= instr_i.op;
        pend_imm <= instr_i.imm;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pc <= PC_RST;
    end else if (pop) begin
      pc <= stack_top;
    end else if (take && jump) begin
      pc <= instr_i.target;
    end else if (take && !is_ret) begin
      pc <= pc_inc;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wreg <= ACC_RST;
    end else if (pop && pend_op == CIX_OP_SUB_EXIT_VALUE) begin
      wreg <= pend_imm;
    end else if (alu.wr_wreg && instr_i.op != CIX_OP_SUB_EXIT_VALUE) begin
      wreg <= alu.result;
    end
  end

  // data memory has no reset; contents are undefined until written
  always_ff @(posedge clk_i) begin
    if (alu.wr_mem) begin
      ram[instr_i.addr] <= alu.result;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flags <= FLAGS_RST;
    end else begin
      if (alu.upd_z) begin
        flags.z <= zero_res;
      end
      if (alu.upd_c) begin
        flags.c <= alu.carry;
      end
    end // ov and ac never written by this subset
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      interrupt_control_reg <= INTERRUPT_CONTROL_REG_RST;
    end else if (pop && pend_op == CIX_OP_INT_EXIT) begin
      interrupt_control_reg[GIE_BIT] <= 1'b1;
    end
  end
endmodule // cix_core

// file: verilog/cix_pkg.sv
// cix_pkg: shared types and constants for the instruction execution subset
// assumes a single 125 MHz clock domain and an outside fetch/decode stage
package cix_pkg;
  localparam int DATA_W = 8;
  localparam int PC_W = 11;
  localparam int RAM_AW = 7;
  localparam int RAM_DEPTH = 128;
  localparam int STACK_DEPTH = 4;
  localparam int SP_W = 2;
  localparam int GIE_BIT = 0;
  localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
  localparam logic [PC_W-1:0] PC_RST = 11'h000;
  localparam logic [DATA_W-1:0] INTERRUPT_CONTROL_REG_RST = 8'h00;
  localparam logic [PC_W-1:0] PC_ONE = 11'h001;
  localparam logic [DATA_W-1:0] BYTE_ONE = 8'h01;
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
  localparam int MSB = DATA_W - 1;

  typedef enum logic [4:0] {
    CIX_OP_IDLE_STEP,
    CIX_OP_INC_MEM,
    CIX_OP_INC_WREG,
    CIX_OP_DIRECT_JUMP,
    CIX_OP_CALL,
    CIX_OP_COPY_MEM_TO_WREG,
    CIX_OP_COPY_IMM_TO_WREG,
    CIX_OP_COPY_WREG_TO_MEM,
    CIX_OP_OR_MEM,
    CIX_OP_OR_IMM,
    CIX_OP_OR_TO_MEM,
    CIX_OP_SUB_EXIT,
    CIX_OP_SUB_EXIT_VALUE,
    CIX_OP_INT_EXIT,
    CIX_OP_ROT_L,
    CIX_OP_ROT_L_WREG,
    CIX_OP_ROT_LC,
    CIX_OP_ROT_LC_WREG,
    CIX_OP_ROT_R,
    CIX_OP_ROT_R_WREG,
    CIX_OP_ROT_RC,
    CIX_OP_ROT_RC_WREG
  } cix_op_t;

  typedef struct packed {
    cix_op_t op;
    logic [RAM_AW-1:0] addr;
    logic [DATA_W-1:0] imm;
    logic [PC_W-1:0] target;
  } cix_instr_t;

  typedef struct packed {
    logic ov;
    logic z;
    logic ac;
    logic c;
  } cix_flags_t;

  localparam cix_flags_t FLAGS_RST = '{ov: 1'b0, z: 1'b0, ac: 1'b0, c: 1'b0};

  typedef struct packed {
    logic [DATA_W-1:0] result;
    logic wr_wreg;
    logic wr_mem;
    logic upd_z;
    logic upd_c;
    logic carry;
  } cix_alu_t;
endpackage

// file: verilog/cix_stack.sv
// cix_stack: four-level return address stack
// assumes callers never nest deeper than four; overflow wraps silently
module cix_stack (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic push_i,
  input wire logic pop_i,
  input wire logic [10:0] push_addr_i,
  output logic [10:0] top_o
);
  import cix_pkg::*;

  logic [PC_W-1:0] mem [STACK_DEPTH];
  logic [SP_W-1:0] sp;
  wire logic [SP_W-1:0] sp_top = sp - 2'h1;

  assign top_o = mem[sp_top];

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sp <= 2'h0;
      for (int i = 0; i < STACK_DEPTH; i++) begin
        mem[i] <= PC_RST;
      end
    end else if (push_i) begin
      mem[sp] <= push_addr_i;
      sp <= sp + 2'h1;
    end else if (pop_i) begin
      sp <= sp_top;
    end
  end
endmodule // cix_stack
